// >>> hdl/hbd_pkg.sv
// Package: shared constants and types for the host buffer DMA setup block
package hbd_pkg;
  // ==========================================================
  // Command codes on the host interface
  localparam logic [7:0] HBD_RD_DMA_SETUP = 8'h21;
  localparam logic [7:0] HBD_WR_DMA_SETUP = 8'hA1;
  localparam logic [7:0] HBD_RD_BYTE_COUNT = 8'h22;
  localparam logic [7:0] HBD_WR_BYTE_COUNT = 8'hA2;
  localparam logic [7:0] HBD_RD_EVENT = 8'h24;
  localparam logic [7:0] HBD_WR_EVENT = 8'hA4;
  // ==========================================================
  // Setup register fields
  localparam int HBD_DIR_BIT = 0;
  localparam int HBD_LIST_BIT = 1;
  localparam int HBD_CNT_USE_BIT = 2;
  localparam int HBD_GO_BIT = 4;
  localparam int HBD_BURST_LO = 5;
  localparam logic [15:0] HBD_SETUP_MASK = 16'h0077;
  localparam logic [15:0] HBD_SETUP_RST = 16'h0000;
  localparam logic [15:0] HBD_COUNT_RST = 16'h0000;
  localparam int HBD_DONE_BIT = 2;
  localparam logic [15:0] HBD_EVENT_MASK = 16'h0004;
  // Buffer limits software must respect
  localparam logic [15:0] HBD_ACK_LIMIT = 16'h1000;
  localparam logic [15:0] HBD_ISO_LIMIT = 16'h0800;
  // ==========================================================
  // Controller APB register offsets
  localparam logic [7:0] HBD_A_CTRL = 8'h00;
  localparam logic [7:0] HBD_A_COUNT = 8'h04;
  localparam logic [7:0] HBD_A_DATA = 8'h08;
  localparam logic [7:0] HBD_A_STATUS = 8'h0C;
  localparam logic [7:0] HBD_A_IRQ_STAT = 8'h10;
  localparam logic [7:0] HBD_A_IRQ_MASK = 8'h14;
  localparam logic [7:0] HBD_A_RDATA = 8'h18;
  localparam int HBD_ST_BITS = 2;
  typedef enum logic [1:0] {
    HBD_BURST_1 = 2'b00, HBD_BURST_4 = 2'b01, HBD_BURST_8 = 2'b10
  } hbd_burst_t;
endpackage

// >>> hdl/hbd_if.sv
// Interface: register command port and DMA handshake between the two ends
`timescale 1ns/1ps
interface hbd_if;
  logic cmd_valid;
  logic cmd_write;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata;
  logic [15:0] cmd_rdata;
  logic cmd_done;
  logic transfer_request;
  logic dma_ack;
  logic dma_write;
  logic [15:0] dma_wdata;
  logic [15:0] dma_rdata;
  logic end_of_transfer;
  modport dev (input cmd_valid, cmd_write, cmd_code, cmd_wdata, dma_ack,
    dma_write, dma_wdata, end_of_transfer, output cmd_rdata, cmd_done,
    transfer_request, dma_rdata);
  modport host (output cmd_valid, cmd_write, cmd_code, cmd_wdata, dma_ack,
    dma_write, dma_wdata, end_of_transfer, input cmd_rdata, cmd_done,
    transfer_request, dma_rdata);
endinterface

// >>> hdl/hbd_device.sv
// Device end: DMA setup, byte count, done flag and buffer data path
// Behaviour
// - Burst field: 00 one, 01 four, 10 eight
// - Go bit zero stops, one enables DMA
// - Go bit self-clears when transfer completes
// - Without counter, partner ends via end_of_transfer
// - Counter mode needs nonzero count to request
// - List select: 0 iso, 1 ack buffer
// - Direction: 0 reads buffer, 1 writes buffer
// - Setup resets zero; bits 15-7, 3 reserved
// - Software loads byte count before each transfer
// - Count loads on every A2H write, whatever the count-use bit
// - Count limits: ack 1000H, iso 800H
// - Reaching count sets transfer done flag bit 2
// - Reaching count updates buffer fill status
// - Byte count 16 bits, codes 22H/A2H, reset 0
// - Done flag on internal or external end
`timescale 1ns/1ps
module hbd_device #(
  parameter int AW = 11 // Word address width of each list buffer
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  hbd_if.dev link, // Host side
  output logic [15:0] buffer_fill_status, // Bytes last moved
  output logic [1:0] burst_words, // Decoded burst: 0=1,1=4,2=8 words
  output logic transfer_done_flag // Done flag level
);
  import hbd_pkg::*;
  // ==========================================================
  // Buffers
  logic [15:0] iso_list_buffer [2**AW];
  logic [15:0] ack_list_buffer [2**AW];
  // ==========================================================
  // State
  logic [15:0] dma_setup_r, dma_setup_nxt;
  logic [15:0] byte_count_r, byte_count_nxt;
  logic [15:0] dma_cnt_r, dma_cnt_nxt;
  logic [15:0] event_r, event_nxt;
  logic [15:0] fill_r, fill_nxt;
  logic [AW-1:0] ptr_r, ptr_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic done_r, done_nxt;
  logic req_r, req_nxt;
  logic [1:0] burst_r, burst_nxt;
  logic [15:0] dout_r, dout_nxt;
  logic cmd_done_r;
  logic take;
  logic go, cnt_use, list_ack, dir_wr, hit, end_any;
  logic [15:0] moved;
  always_comb begin
    // Valid stands two cycles; acting on both would apply a write twice
    take = link.cmd_valid && !cmd_done_r;
    go = dma_setup_r[HBD_GO_BIT];
    cnt_use = dma_setup_r[HBD_CNT_USE_BIT];
    list_ack = dma_setup_r[HBD_LIST_BIT];
    dir_wr = dma_setup_r[HBD_DIR_BIT];
    moved = dma_cnt_r + 16'h0002;
    hit = link.dma_ack && cnt_use && (moved >= byte_count_r);
    end_any = (link.dma_ack && hit) || link.end_of_transfer;
  end
  always_comb begin
    dma_setup_nxt = dma_setup_r;
    byte_count_nxt = byte_count_r;
    dma_cnt_nxt = dma_cnt_r;
    event_nxt = event_r;
    fill_nxt = fill_r;
    ptr_nxt = ptr_r;
    rdata_nxt = rdata_r;
    done_nxt = 1'b0;
    dout_nxt = dout_r;
    if (take && link.cmd_write) begin
      unique case (link.cmd_code)
        HBD_WR_DMA_SETUP: begin
          // Reserved bits stay zero
          dma_setup_nxt = link.cmd_wdata & HBD_SETUP_MASK;
          ptr_nxt = '0;
          dma_cnt_nxt = '0;
        end
        HBD_WR_BYTE_COUNT: begin
          byte_count_nxt = link.cmd_wdata;
        end
        HBD_WR_EVENT: begin
          event_nxt = event_r & ~link.cmd_wdata;
        end
        default: begin
        end
      endcase
    end else if (take) begin
      unique case (link.cmd_code)
        HBD_RD_DMA_SETUP: begin
          rdata_nxt = dma_setup_r;
        end
        HBD_RD_BYTE_COUNT: begin
          rdata_nxt = byte_count_r;
        end
        HBD_RD_EVENT: begin
          rdata_nxt = event_r;
        end
        default: begin
          rdata_nxt = 16'h0000;
        end
      endcase
    end
    if (go && link.dma_ack) begin
      ptr_nxt = ptr_r + 1'b1;
      if (cnt_use) begin
        dma_cnt_nxt = moved;
      end
      if (!dir_wr) begin
        dout_nxt = list_ack ? ack_list_buffer[ptr_r]
                            : iso_list_buffer[ptr_r];
      end
    end
    if (go && end_any) begin
      dma_setup_nxt[HBD_GO_BIT] = 1'b0;
      event_nxt[HBD_DONE_BIT] = 1'b1; // Set wins over clear
      // Bytes moved so far, including one word acknowledged in this cycle
      fill_nxt = cnt_use ? moved : 16'({ptr_nxt, 1'b0});
      done_nxt = 1'b1;
    end
    event_nxt = event_nxt & HBD_EVENT_MASK;
  end
  // Request only with a nonzero count in counter mode
  always_comb begin
    req_nxt = go && !(go && end_any) &&
      (!cnt_use || byte_count_r != 16'h0000);
    burst_nxt = 2'b00;
    unique case (hbd_burst_t'(dma_setup_r[HBD_BURST_LO +: 2]))
      HBD_BURST_1: burst_nxt = 2'd0;
      HBD_BURST_4: burst_nxt = 2'd1;
      HBD_BURST_8: burst_nxt = 2'd2;
      default: burst_nxt = 2'd0; // Reserved code acts as single
    endcase
  end
  always_ff @(posedge pclk) begin
    if (go && link.dma_ack && dir_wr) begin
      if (list_ack) begin
        ack_list_buffer[ptr_r] <= link.dma_wdata;
      end else begin
        iso_list_buffer[ptr_r] <= link.dma_wdata;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_setup_r <= HBD_SETUP_RST;
      byte_count_r <= HBD_COUNT_RST;
      dma_cnt_r <= 16'h0000;
      event_r <= 16'h0000;
      fill_r <= 16'h0000;
      ptr_r <= '0;
      rdata_r <= 16'h0000;
      done_r <= 1'b0;
      req_r <= 1'b0;
      burst_r <= 2'b00;
      dout_r <= 16'h0000;
    end else begin
      dma_setup_r <= dma_setup_nxt;
      byte_count_r <= byte_count_nxt;
      dma_cnt_r <= dma_cnt_nxt;
      event_r <= event_nxt;
      fill_r <= fill_nxt;
      ptr_r <= ptr_nxt;
      rdata_r <= rdata_nxt;
      done_r <= done_nxt;
      req_r <= req_nxt;
      burst_r <= burst_nxt;
      dout_r <= dout_nxt;
    end
  end
  // ==========================================================
  // Outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_done_r <= 1'b0;
    end else begin
      cmd_done_r <= take;
    end
  end
  assign link.cmd_done = cmd_done_r;
  assign link.cmd_rdata = rdata_r;
  assign link.transfer_request = req_r;
  assign link.dma_rdata = dout_r;
  assign buffer_fill_status = fill_r;
  assign burst_words = burst_r;
  assign transfer_done_flag = event_r[HBD_DONE_BIT];
endmodule

// >>> hdl/hbd_host.sv
// Host end: APB-programmed controller that drives the device port
`timescale 1ns/1ps
module hbd_host (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic irq, // Level interrupt
  hbd_if.host link // Device side
);
  import hbd_pkg::*;
  // ==========================================================
  // Registers: CTRL[0] start cmd, [1] write, [15:8] code, [16] dma ack,
  // [17] dma write, [18] end_of_transfer pulse
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] data_r, data_nxt;
  logic [15:0] rd_r, rd_nxt;
  logic busy_r, busy_nxt;
  logic [HBD_ST_BITS-1:0] ist_r, ist_nxt, imask_r, imask_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, irq_r, irq_nxt;
  logic req_d_r;
  logic wr, rd, acc;
  // Events: bit0 command answered, bit1 request rose
  logic [HBD_ST_BITS-1:0] ev;
  always_comb begin
    acc = psel && penable && !pready_r;
    // A write lands only at the edge where pready is seen high
    wr = psel && penable && pwrite && pready_r;
    rd = acc && !pwrite;
    ev = {link.transfer_request && !req_d_r, link.cmd_done};
    ctrl_nxt = ctrl_r;
    ctrl_nxt[0] = 1'b0;
    ctrl_nxt[16] = 1'b0;
    ctrl_nxt[18] = 1'b0;
    cnt_nxt = cnt_r;
    data_nxt = data_r;
    rd_nxt = link.cmd_done ? link.cmd_rdata : rd_r;
    busy_nxt = (busy_r && !link.cmd_done) || ctrl_r[0];
    imask_nxt = imask_r;
    ist_nxt = ist_r;
    prdata_nxt = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    if (wr) begin
      unique case (paddr)
        HBD_A_CTRL: ctrl_nxt = pwdata;
        HBD_A_COUNT: cnt_nxt = pwdata[15:0];
        HBD_A_DATA: data_nxt = pwdata[15:0];
        HBD_A_IRQ_STAT: ist_nxt = ist_r & ~pwdata[HBD_ST_BITS-1:0];
        HBD_A_IRQ_MASK: imask_nxt = pwdata[HBD_ST_BITS-1:0];
        default: ;
      endcase
    end
    if (acc && pwrite) begin
      pslverr_nxt = !(paddr inside {HBD_A_CTRL, HBD_A_COUNT, HBD_A_DATA,
                      HBD_A_IRQ_STAT, HBD_A_IRQ_MASK});
    end else if (rd) begin
      unique case (paddr)
        HBD_A_CTRL: prdata_nxt = ctrl_r;
        HBD_A_COUNT: prdata_nxt = {16'h0000, cnt_r};
        HBD_A_DATA: prdata_nxt = {16'h0000, link.dma_rdata};
        HBD_A_STATUS: prdata_nxt = {30'h0000_0000,
                                    link.transfer_request, busy_r};
        HBD_A_IRQ_STAT: prdata_nxt = {30'h0000_0000, ist_r};
        HBD_A_IRQ_MASK: prdata_nxt = {30'h0000_0000, imask_r};
        HBD_A_RDATA: prdata_nxt = {16'h0000, rd_r};
        default: pslverr_nxt = 1'b1;
      endcase
    end
    ist_nxt = ist_nxt | ev; // Set wins over clear
    pready_nxt = acc;
    irq_nxt = |(ist_nxt & imask_nxt);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 32'h0000_0000;
      cnt_r <= 16'h0000;
      data_r <= 16'h0000;
      rd_r <= 16'h0000;
      busy_r <= 1'b0;
      ist_r <= '0;
      imask_r <= '0;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r <= 1'b0;
      req_d_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      cnt_r <= cnt_nxt;
      data_r <= data_nxt;
      rd_r <= rd_nxt;
      busy_r <= busy_nxt;
      ist_r <= ist_nxt;
      imask_r <= imask_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r <= irq_nxt;
      req_d_r <= link.transfer_request;
    end
  end
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  // Command held until device answers
  assign link.cmd_valid = busy_r;
  assign link.cmd_write = ctrl_r[1];
  assign link.cmd_code = ctrl_r[15:8];
  assign link.cmd_wdata = cnt_r;
  assign link.dma_ack = ctrl_r[16];
  assign link.dma_write = ctrl_r[17];
  assign link.dma_wdata = data_r;
  assign link.end_of_transfer = ctrl_r[18];
endmodule

// >>> tb/hbd_assertions.sv
// Checker: timing and rule assertions on the device link
`timescale 1ns/1ps
module hbd_assertions (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic cmd_valid, // Command valid
  input wire logic cmd_write, // Command direction
  input wire logic [7:0] cmd_code, // Command code
  input wire logic [15:0] cmd_wdata, // Command write data
  input wire logic [15:0] cmd_rdata, // Command read data
  input wire logic cmd_done, // Command done
  input wire logic transfer_request, // Word request
  input wire logic dma_ack, // Word acknowledge
  input wire logic end_of_transfer // External end
);
  import hbd_pkg::*;
  // ==========
  // Shadow of the last written count and setup, and bytes acknowledged
  logic [15:0] cnt_r, cnt_nxt, set_r, set_nxt;
  logic [16:0] sum_r, sum_nxt;
  logic wr;
  logic last;
  assign wr = cmd_done && cmd_write;
  assign last = sum_r + 17'h0_0002 >= {1'b0, cnt_r};
  always_comb begin
    cnt_nxt = cnt_r;
    set_nxt = set_r;
    sum_nxt = sum_r;
    if (wr && cmd_code == HBD_WR_BYTE_COUNT)
      cnt_nxt = cmd_wdata;
    if (wr && cmd_code == HBD_WR_DMA_SETUP) begin
      set_nxt = cmd_wdata;
      sum_nxt = 17'h0_0000;
    end else if (dma_ack && transfer_request)
      sum_nxt = sum_r + 17'h0_0002;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
      set_r <= 16'h0000;
      sum_r <= 17'h0_0000;
    end else begin
      cnt_r <= cnt_nxt;
      set_r <= set_nxt;
      sum_r <= sum_nxt;
    end
  end
  // ==========
  // Assertions
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_answer; $rose(cmd_valid) |=> cmd_done; endproperty
  a_answer: assert property (p_answer)
    else $error("command not answered next cycle");
  property p_cause; cmd_done |-> $past(cmd_valid); endproperty
  a_cause: assert property (p_cause)
    else $error("done without a command");
  property p_count; cmd_done && !cmd_write &&
    cmd_code == HBD_RD_BYTE_COUNT |-> cmd_rdata == cnt_r; endproperty
  a_count: assert property (p_count)
    else $error("byte count readback wrong");
  property p_rsvd; cmd_done && !cmd_write && cmd_code == HBD_RD_DMA_SETUP
    |-> (cmd_rdata & ~HBD_SETUP_MASK) == 16'h0000; endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved setup bits not zero");
  property p_req; $rose(transfer_request) |-> set_r[HBD_GO_BIT] &&
    (!set_r[HBD_CNT_USE_BIT] || cnt_r != 16'h0000); endproperty
  a_req: assert property (p_req)
    else $error("request raised without cause");
  property p_stop; wr && cmd_code == HBD_WR_DMA_SETUP &&
    !cmd_wdata[HBD_GO_BIT] |-> ##[1:2] !transfer_request; endproperty
  a_stop: assert property (p_stop)
    else $error("request kept after stop");
  property p_eot; end_of_transfer && transfer_request
    |-> ##[1:2] !transfer_request; endproperty
  a_eot: assert property (p_eot)
    else $error("external end ignored");
  property p_end; dma_ack && transfer_request && set_r[HBD_CNT_USE_BIT]
    && last |-> ##[1:2] !transfer_request; endproperty
  a_end: assert property (p_end)
    else $error("count reached but request kept");
  property p_early; dma_ack && transfer_request && set_r[HBD_CNT_USE_BIT]
    && !last |=> transfer_request; endproperty
  a_early: assert property (p_early)
    else $error("transfer ended before count");
endmodule

// >>> tb/host_buffer_dma_setup_test.sv
// Testbench: drives the host end over APB and checks both ends
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module host_buffer_dma_setup_test;
  import hbd_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, irq, err, flag;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [1:0] burst;
  logic [15:0] fill, r0, r1;
  int errors = 0, tests_run = 0;
  hbd_if link_if();
  hbd_host hbd_host_i(.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .link(link_if));
  hbd_device #(.AW(11)) hbd_device_i(.pclk(pclk), .presetn(presetn),
    .link(link_if), .buffer_fill_status(fill), .burst_words(burst),
    .transfer_done_flag(flag));
  hbd_assertions hbd_assertions_i(.pclk(pclk), .presetn(presetn),
    .cmd_valid(link_if.cmd_valid), .cmd_write(link_if.cmd_write),
    .cmd_code(link_if.cmd_code), .cmd_wdata(link_if.cmd_wdata),
    .cmd_rdata(link_if.cmd_rdata), .cmd_done(link_if.cmd_done),
    .transfer_request(link_if.transfer_request),
    .dma_ack(link_if.dma_ack), .end_of_transfer(link_if.end_of_transfer));
  always #50 pclk = ~pclk;
  // ==========
  // Bus tasks
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Device command through the host; read data lands in rd
  task automatic dev(input logic w, input logic [7:0] c,
    input logic [15:0] d);
    apb(1'b1, HBD_A_COUNT, {16'h0000, d});
    apb(1'b1, HBD_A_CTRL, {16'h0000, c, 6'h00, w, 1'b1});
    do apb(1'b0, HBD_A_STATUS, 32'h0000_0000); while (rd[0] !== 1'b0);
    apb(1'b0, HBD_A_RDATA, 32'h0000_0000);
  endtask
  task automatic req(input logic e);
    apb(1'b0, HBD_A_STATUS, 32'h0000_0000);
    `CHK(rd[1], e)
  endtask
  task automatic ack(input logic [15:0] w);
    apb(1'b1, HBD_A_DATA, {16'h0000, w});
    apb(1'b1, HBD_A_CTRL, 32'h0001_0000);
    apb(1'b0, HBD_A_DATA, 32'h0000_0000);
  endtask
  task automatic fin;
    dev(1'b0, HBD_RD_EVENT, 16'h0000);
    `CHK(rd[HBD_DONE_BIT], 1'b1)
    `CHK(flag, 1'b1)
    dev(1'b1, HBD_WR_EVENT, 16'h0004);
    `CHK(flag, 1'b0)
  endtask
  // Four-byte counted transfer, two words
  task automatic xfer(input logic [15:0] s, w0, w1);
    dev(1'b1, HBD_WR_BYTE_COUNT, 16'h0004);
    dev(1'b1, HBD_WR_DMA_SETUP, s);
    req(1'b1);
    ack(w0);
    r0 = rd[15:0];
    req(1'b1);
    ack(w1);
    r1 = rd[15:0];
    req(1'b0);
    dev(1'b0, HBD_RD_DMA_SETUP, 16'h0000);
    `CHK(rd[15:0], s & 16'hFFEF)
    `CHK(fill, 16'h0004)
    fin();
  endtask
  task automatic test_done;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========
  // Watchdog: the whole run needs about a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    dev(1'b0, HBD_RD_DMA_SETUP, 16'h0000);
    `CHK(rd[15:0], HBD_SETUP_RST)
    dev(1'b0, HBD_RD_BYTE_COUNT, 16'h0000);
    `CHK(rd[15:0], HBD_COUNT_RST)
    // Zero count in counted mode must hold the request back
    dev(1'b1, HBD_WR_DMA_SETUP, 16'hFFFF);
    dev(1'b0, HBD_RD_DMA_SETUP, 16'h0000);
    `CHK(rd[15:0], 16'h0077)
    req(1'b0);
    for (int i = 0; i < 3; i++) begin
      dev(1'b1, HBD_WR_DMA_SETUP, {9'h000, i[1:0], 5'h00});
      `CHK(burst, i[1:0])
    end
    xfer(16'h0015, 16'hA1A1, 16'h5E5E);
    xfer(16'h0017, 16'h0F0F, 16'hC3C3);
    xfer(16'h0014, 16'h0000, 16'h0000);
    `CHK(r0, 16'hA1A1)
    `CHK(r1, 16'h5E5E)
    xfer(16'h0016, 16'h0000, 16'h0000);
    `CHK(r0, 16'h0F0F)
    `CHK(r1, 16'hC3C3)
    dev(1'b0, HBD_RD_BYTE_COUNT, 16'h0000);
    `CHK(rd[15:0], 16'h0004)
    dev(1'b1, HBD_WR_DMA_SETUP, 16'h0010);
    req(1'b1);
    ack(16'h1234);
    apb(1'b1, HBD_A_CTRL, 32'h0004_0000);
    req(1'b0);
    `CHK(fill, 16'h0002)
    fin();
    dev(1'b1, HBD_WR_DMA_SETUP, 16'h0010);
    req(1'b1);
    dev(1'b1, HBD_WR_DMA_SETUP, 16'h0000);
    req(1'b0);
    `CHK(flag, 1'b0)
    // A one in the mask lets the pending bit through
    apb(1'b1, HBD_A_IRQ_MASK, 32'h0000_0003);
    apb(1'b0, HBD_A_IRQ_STAT, 32'h0000_0000);
    `CHK(rd[0], 1'b1)
    `CHK(irq, 1'b1)
    apb(1'b1, HBD_A_IRQ_MASK, 32'h0000_0000);
    apb(1'b0, HBD_A_IRQ_STAT, 32'h0000_0000);
    `CHK(irq, 1'b0)
    apb(1'b1, HBD_A_IRQ_MASK, 32'h0000_0003);
    apb(1'b1, HBD_A_IRQ_STAT, 32'h0000_0003);
    apb(1'b0, HBD_A_IRQ_STAT, 32'h0000_0000);
    `CHK(irq, 1'b0)
    apb(1'b0, 8'h40, 32'h0000_0000);
    `CHK(err, 1'b1)
    test_done();
  end
endmodule
